/* dv/peripheral_soft_reset_regs_tb.sv */
// Purpose: self-checking bench for the peripheral soft reset registers
// Assumes: slave answers in its own time, masks held steady per transfer
// Notes:   driver queues expected answers, a monitor compares at pready
`timescale 1ns/100ps
module peripheral_soft_reset_regs_tb;
  // bits that hold a peripheral reset line, all else reads zero
  localparam logic [31:0] writable_0 = 32'h0011_0048;
  localparam logic [31:0] writable_1 = 32'h0107_1013;

  typedef struct packed {
    logic                        rd;
    logic                        err;
    logic [31:0]                 data;
    soft_reset_pkg::periph_rst_t rst;
  } note_t;

  logic                        pclk;
  logic                        presetn;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata;
  logic [3:0]                  pstrb;
  logic [31:0]                 capability_mask_1;
  logic [31:0]                 capability_mask_2;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  soft_reset_pkg::periph_rst_t periph_rst;
  logic [31:0]                 m0;
  logic [31:0]                 m1;
  logic [31:0]                 cap1;
  logic [31:0]                 cap2;
  logic [31:0]                 r;
  note_t                       notes[$];
  note_t                       got;
  int                          errors;
  int                          num_checks;
  integer                      seed;

  peripheral_soft_reset_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .capability_mask_1(capability_mask_1),
    .capability_mask_2(capability_mask_2),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_rst(periph_rst)
  );

  // free running 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // reset lines in struct order, taken straight from the bit map
  function automatic soft_reset_pkg::periph_rst_t exp_rst(
    input logic [31:0] a, input logic [31:0] b);
    exp_rst = '{a[20], a[16], a[6], a[3], b[24], b[18], b[17], b[16],
                b[12], b[4], b[1], b[0]};
  endfunction

  task automatic cmp_data(input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e) begin
      errors++;
      $display("unexpected at %0t: read data %h, expected %h", $time, a, e);
    end
  endtask

  task automatic cmp_err(input logic e, input logic a);
    num_checks++;
    if (a !== e) begin
      errors++;
      $display("unexpected at %0t: slave error %b, expected %b", $time, a, e);
    end
  endtask

  task automatic cmp_rst(input soft_reset_pkg::periph_rst_t e,
                         input soft_reset_pkg::periph_rst_t a);
    num_checks++;
    if (a !== e) begin
      errors++;
      $display("unexpected at %0t: reset lines %h, expected %h", $time, a, e);
    end
  endtask

  // one apb transfer; the model commits before the bus does, the note
  // keeps the reset lines as they stand during the access phase
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    note_t       n;
    logic [31:0] wm;
    n.rd   = !wr;
    n.rst  = exp_rst(m0, m1);
    n.err  = (a !== 12'h040) && (a !== 12'h044);
    n.data = (wr || n.err) ? 32'h0000_0000 : (a[2] ? m1 : m0);
    notes.push_back(n);
    wm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    if (wr && a === 12'h040) begin
      wm = wm & cap1 & writable_0;
      m0 = (m0 & ~wm) | (d & wm);
    end
    if (wr && a === 12'h044) begin
      wm = wm & cap2 & writable_1;
      m1 = (m1 & ~wm) | (d & wm);
    end
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until pready is sampled high at a rising edge;
    // a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // monitor: pready settles before the falling edge, so sample there
  always @(negedge pclk) begin
    if (presetn === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        errors++;
        $display("unexpected at %0t: answer with nothing pending", $time);
      end else begin
        got = notes.pop_front();
        cmp_err(got.err, pslverr);
        if (got.rd) cmp_data(got.data, prdata);
        cmp_rst(got.rst, periph_rst);
      end
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog, well past the few thousand cycles the run needs
  initial begin
    #(100 * 20000);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end

  // main sequence
  initial begin
    seed = 3804;
    errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    cap1 = 32'hFFFF_FFFF;
    cap2 = 32'hFFFF_FFFF;
    capability_mask_1 = cap1;
    capability_mask_2 = cap2;
    m0 = 32'h0000_0000;
    m1 = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp_rst('0, periph_rst);
    apb(1'b0, 12'h040, 32'h0000_0000, 4'h0);
    apb(1'b0, 12'h044, 32'h0000_0000, 4'h0);
    // walking one over every bit, reserved places must stay zero
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, 12'h040, 32'h0000_0001 << i, 4'hF);
      apb(1'b1, 12'h044, 32'h0000_0001 << i, 4'hF);
      apb(1'b0, 12'h040, 32'h0000_0000, 4'h0);
      apb(1'b0, 12'h044, 32'h0000_0000, 4'h0);
    end
    // random masks, data, strobes and addresses, unmapped ones included
    repeat (300) begin
      r = $random(seed);
      if (r[8]) begin
        cap1 = $random(seed);
        cap2 = $random(seed);
        capability_mask_1 <= cap1;
        capability_mask_2 <= cap2;
      end
      apb(r[0], r[2:1] == 2'b11 ? r[31:20] : (r[1] ? 12'h044 : 12'h040),
          $random(seed), r[7:4]);
      if (r[9]) apb(1'b0, r[3] ? 12'h044 : 12'h040, 32'h0000_0000, 4'h0);
    end
    // reset in mid-run must drop every held peripheral
    cap1 = 32'hFFFF_FFFF;
    cap2 = 32'hFFFF_FFFF;
    capability_mask_1 <= cap1;
    capability_mask_2 <= cap2;
    apb(1'b1, 12'h040, 32'hFFFF_FFFF, 4'hF);
    apb(1'b1, 12'h044, 32'hFFFF_FFFF, 4'hF);
    // every line must be held before reset, else the drop proves nothing
    @(negedge pclk);
    cmp_rst(exp_rst(m0, m1), periph_rst);
    @(posedge pclk);
    presetn <= 1'b0;
    m0 = 32'h0000_0000;
    m1 = 32'h0000_0000;
    repeat (2) @(negedge pclk);
    cmp_rst('0, periph_rst);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h040, 32'h0000_0000, 4'h0);
    apb(1'b0, 12'h044, 32'h0000_0000, 4'h0);
    repeat (2) @(posedge pclk);
    results;
  end
endmodule // peripheral_soft_reset_regs_tb

/* rtl/masked_write_cell.sv */
// Purpose: next value of one 32-bit register under a masked bus write
// Assumes: byte strobes follow apb4, one strobe per eight data bits
// Notes:   a bit changes only if written, strobed, present and implemented
`timescale 1ns/100ps
module masked_write_cell #(
  parameter logic [31:0] WMASK = 32'h0000_0000
) (
  input  wire logic [31:0] cur,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  strb,
  input  wire logic [31:0] cap,
  input  wire logic        en,
  output logic      [31:0] nxt
);

  // per bit select; unimplemented bits are forced low so they read zero
  for (genvar i = 0; i < 32; i++) begin : g_bit
    if (WMASK[i]) begin : g_rw
      assign nxt[i] = (en && strb[i/8] && cap[i]) ? wdata[i] : cur[i];
    end else begin : g_ro
      assign nxt[i] = 1'b0;
    end
  end

endmodule // masked_write_cell

/* rtl/peripheral_soft_reset_regs.sv */
// Purpose: apb slave holding the two peripheral software reset registers
// Assumes: capability masks come from another block, stable between writes
// Notes:   answer in the first access cycle; unmapped words get pslverr
`timescale 1ns/100ps
`include "soft_reset_regs.svh"
module peripheral_soft_reset_regs (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  input  wire logic [31:0]                 capability_mask_1,
  input  wire logic [31:0]                 capability_mask_2,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output soft_reset_pkg::periph_rst_t      periph_rst
);

  soft_reset_pkg::state_t state_reg;
  soft_reset_pkg::state_t state_next;

  logic        setup_phase;
  logic        commit;
  logic        hit_0;
  logic        hit_1;
  logic        mapped;
  logic        wr_0;
  logic        wr_1;
  logic [31:0] ctl_0_wr;
  logic [31:0] ctl_1_wr;

  // address decode; misaligned addresses never match a register
  assign hit_0  = (paddr == `SRST_CTL_0_OFFSET);
  assign hit_1  = (paddr == `SRST_CTL_1_OFFSET);
  assign mapped = hit_0 || hit_1;

  // transfer phases as seen by the slave
  assign setup_phase = psel && !penable;
  assign commit      = psel && penable && state_reg.ready;

  // a write lands only at the edge where pready is sampled high
  assign wr_0 = commit && pwrite && hit_0;
  assign wr_1 = commit && pwrite && hit_1;

  // masked write of the first register
  masked_write_cell #(
    .WMASK (`SRST_CTL_0_WMASK)
  ) u_cell_0 (
    .cur   (state_reg.ctl_0),
    .wdata (pwdata),
    .strb  (pstrb),
    .cap   (capability_mask_1),
    .en    (wr_0),
    .nxt   (ctl_0_wr)
  );

  // masked write of the second register
  masked_write_cell #(
    .WMASK (`SRST_CTL_1_WMASK)
  ) u_cell_1 (
    .cur   (state_reg.ctl_1),
    .wdata (pwdata),
    .strb  (pstrb),
    .cap   (capability_mask_2),
    .en    (wr_1),
    .nxt   (ctl_1_wr)
  );

  // next state; read data is captured in setup so prdata leaves a flop
  always_comb begin
    state_next        = state_reg;
    state_next.ctl_0  = ctl_0_wr;
    state_next.ctl_1  = ctl_1_wr;
    state_next.ready  = setup_phase;
    state_next.slverr = setup_phase && !mapped;
    if (setup_phase) begin
      // reserved bits are already zero inside the registers
      if (hit_0 && !pwrite) begin
        state_next.rdata = state_reg.ctl_0;
      end else if (hit_1 && !pwrite) begin
        state_next.rdata = state_reg.ctl_1;
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end else if (commit) begin
      // drop read data after the transfer so stale values never linger
      state_next.rdata = 32'h0000_0000;
    end
  end

  // single state register; everything clears on system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.ctl_0  <= `SRST_RESET_VALUE;
      state_reg.ctl_1  <= `SRST_RESET_VALUE;
      state_reg.rdata  <= 32'h0000_0000;
      state_reg.ready  <= 1'b0;
      state_reg.slverr <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // bus answer straight from flops
  assign prdata  = state_reg.rdata;
  assign pready  = state_reg.ready;
  assign pslverr = state_reg.slverr;

  // reset lines follow the stored bits, so a one holds the unit in reset
  assign periph_rst.pwm_reset_bit =
    state_reg.ctl_0[`SRST_PWM_BIT];
  assign periph_rst.adc_reset_bit =
    state_reg.ctl_0[`SRST_ADC_BIT];
  assign periph_rst.hibernation_reset_bit =
    state_reg.ctl_0[`SRST_HIBERNATE_BIT];
  assign periph_rst.watchdog_reset_bit =
    state_reg.ctl_0[`SRST_WATCHDOG_BIT];
  assign periph_rst.comparator_zero_reset_bit =
    state_reg.ctl_1[`SRST_COMP_BIT];
  assign periph_rst.timer_two_reset_bit =
    state_reg.ctl_1[`SRST_TIMER_TWO_BIT];
  assign periph_rst.timer_one_reset_bit =
    state_reg.ctl_1[`SRST_TIMER_ONE_BIT];
  assign periph_rst.timer_zero_reset_bit =
    state_reg.ctl_1[`SRST_TIMER_ZERO_BIT];
  assign periph_rst.two_wire_zero_reset_bit =
    state_reg.ctl_1[`SRST_TWO_WIRE_BIT];
  assign periph_rst.sync_serial_zero_reset_bit =
    state_reg.ctl_1[`SRST_SYNC_SER_BIT];
  assign periph_rst.async_serial_one_reset_bit =
    state_reg.ctl_1[`SRST_ASYNC1_BIT];
  assign periph_rst.async_serial_zero_reset_bit =
    state_reg.ctl_1[`SRST_ASYNC0_BIT];

  // checks below watch only what this block drives
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bits outside the capability mask never move on a write
  property p_mask_0;
    wr_0 |=> ((state_reg.ctl_0 ^ $past(state_reg.ctl_0))
              & ~$past(capability_mask_1)) == 32'h0000_0000;
  endproperty
  a_mask_0: assert property (p_mask_0)
    else $error("ctl_0 bit changed outside capability mask");

  property p_mask_1;
    wr_1 |=> ((state_reg.ctl_1 ^ $past(state_reg.ctl_1))
              & ~$past(capability_mask_2)) == 32'h0000_0000;
  endproperty
  a_mask_1: assert property (p_mask_1)
    else $error("ctl_1 bit changed outside capability mask");

  // a permitted one on bit 20 raises the modulator reset next cycle
  property p_pwm_set;
    (wr_0 && pwdata[`SRST_PWM_BIT] && pstrb[2]
     && capability_mask_1[`SRST_PWM_BIT])
    |=> periph_rst.pwm_reset_bit;
  endproperty
  a_pwm_set: assert property (p_pwm_set)
    else $error("modulator reset not raised by write");

  // a read of ctl_0 shows the converter line as it stood in setup
  property p_adc_read;
    (setup_phase && hit_0 && !pwrite)
    |=> prdata[`SRST_ADC_BIT] == $past(periph_rst.adc_reset_bit);
  endproperty
  a_adc_read: assert property (p_adc_read)
    else $error("converter reset bit misreported");

  // without a write to ctl_0 the hibernation line holds
  property p_hib_hold;
    !wr_0 |=> $stable(periph_rst.hibernation_reset_bit);
  endproperty
  a_hib_hold: assert property (p_hib_hold)
    else $error("hibernation reset moved without a write");

  // a permitted zero on bit 3 releases the watchdog
  property p_wdt_clear;
    (wr_0 && !pwdata[`SRST_WATCHDOG_BIT] && pstrb[0]
     && capability_mask_1[`SRST_WATCHDOG_BIT])
    |=> !periph_rst.watchdog_reset_bit;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog reset not released by write");

  // comparator line follows a permitted write of bit 24
  property p_comp_wr;
    (wr_1 && pstrb[3] && capability_mask_2[`SRST_COMP_BIT])
    |=> periph_rst.comparator_zero_reset_bit
        == $past(pwdata[`SRST_COMP_BIT]);
  endproperty
  a_comp_wr: assert property (p_comp_wr)
    else $error("comparator reset does not follow write");

  // timers take their three bits together
  property p_timers;
    (wr_1 && pstrb[2] && (&capability_mask_2[18:16]))
    |=> {periph_rst.timer_two_reset_bit,
         periph_rst.timer_one_reset_bit,
         periph_rst.timer_zero_reset_bit} == $past(pwdata[18:16]);
  endproperty
  a_timers: assert property (p_timers)
    else $error("timer resets do not follow write");

  // uart lines follow a permitted write of the low byte
  property p_async;
    (wr_1 && pstrb[0] && (&capability_mask_2[1:0]))
    |=> {periph_rst.async_serial_one_reset_bit,
         periph_rst.async_serial_zero_reset_bit} == $past(pwdata[1:0]);
  endproperty
  a_async: assert property (p_async)
    else $error("uart resets do not follow write");

  // reserved bits read zero in both registers
  property p_reserved;
    (commit && !pwrite && hit_0)
    |-> (prdata & ~`SRST_CTL_0_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit of ctl_0 read as one");

  property p_reserved_1;
    (commit && !pwrite && hit_1)
    |-> (prdata & ~`SRST_CTL_1_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_1: assert property (p_reserved_1)
    else $error("reserved bit of ctl_1 read as one");

  // first cycle after release starts from cleared registers
  property p_reset_zero;
    $rose(presetn)
    |-> (state_reg.ctl_0 == `SRST_RESET_VALUE)
        && (state_reg.ctl_1 == `SRST_RESET_VALUE);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

  // a held one keeps the sync serial unit in reset into the next cycle unless ctl_1 is written
  property p_hold;
    (periph_rst.sync_serial_zero_reset_bit && !wr_1)
    |=> periph_rst.sync_serial_zero_reset_bit;
  endproperty
  a_hold: assert property (p_hold)
    else $error("serial reset dropped without a write");

  // the answer comes exactly one cycle after setup
  property p_ready_timing;
    setup_phase |=> pready ##1 !pready;
  endproperty
  a_ready_timing: assert property (p_ready_timing)
    else $error("pready not a single cycle after setup");

  // unmapped access answers with an error and no data
  property p_unmapped;
    (setup_phase && !mapped) |=> pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  // a permitted zero on bit 20 lets the modulator run again
  property p_pwm_clear;
    (wr_0 && !pwdata[`SRST_PWM_BIT] && pstrb[2]
     && capability_mask_1[`SRST_PWM_BIT])
    |=> !periph_rst.pwm_reset_bit;
  endproperty
  a_pwm_clear: assert property (p_pwm_clear)
    else $error("modulator reset not released by write");

  // hibernation line follows a permitted write of bit 6
  property p_hib_wr;
    (wr_0 && pstrb[0] && capability_mask_1[`SRST_HIBERNATE_BIT])
    |=> periph_rst.hibernation_reset_bit
        == $past(pwdata[`SRST_HIBERNATE_BIT]);
  endproperty
  a_hib_wr: assert property (p_hib_wr)
    else $error("hibernation reset does not follow write");

  // two-wire line follows a permitted write of bit 12
  property p_two_wire;
    (wr_1 && pstrb[1] && capability_mask_2[`SRST_TWO_WIRE_BIT])
    |=> periph_rst.two_wire_zero_reset_bit
        == $past(pwdata[`SRST_TWO_WIRE_BIT]);
  endproperty
  a_two_wire: assert property (p_two_wire)
    else $error("two-wire reset does not follow write");

  // sync serial line follows a permitted write of bit 4
  property p_sync_serial;
    (wr_1 && pstrb[0] && capability_mask_2[`SRST_SYNC_SER_BIT])
    |=> periph_rst.sync_serial_zero_reset_bit
        == $past(pwdata[`SRST_SYNC_SER_BIT]);
  endproperty
  a_sync_serial: assert property (p_sync_serial)
    else $error("serial reset does not follow write");

  // unstrobed bytes keep their value, so partial writes are safe
  property p_strobe_0;
    wr_0 |=> ((state_reg.ctl_0 ^ $past(state_reg.ctl_0))
              & ~$past({{8{pstrb[3]}}, {8{pstrb[2]}},
                        {8{pstrb[1]}}, {8{pstrb[0]}}})) == 32'h0000_0000;
  endproperty
  a_strobe_0: assert property (p_strobe_0)
    else $error("unstrobed byte of ctl_0 changed");

  // reads and unmapped accesses leave both registers alone
  property p_no_write;
    (commit && (!pwrite || !mapped))
    |=> $stable(state_reg.ctl_0) && $stable(state_reg.ctl_1);
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("register changed without a mapped write");

  // reserved places never hold a one, whatever the masks allow
  property p_reserved_store;
    ((state_reg.ctl_0 & ~`SRST_CTL_0_WMASK) == 32'h0000_0000)
    && ((state_reg.ctl_1 & ~`SRST_CTL_1_WMASK) == 32'h0000_0000);
  endproperty
  a_reserved_store: assert property (p_reserved_store)
    else $error("reserved register bit holds a one");

  // the error flag only ever rides on pready
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr raised without pready");

  // read data is zero outside the answer cycle
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data left on the bus");

  // mapped words never answer with an error
  property p_mapped_ok;
    (setup_phase && mapped) |=> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access flagged as error");

endmodule // peripheral_soft_reset_regs

/* rtl/soft_reset_pkg.sv */
// Purpose: types shared by the soft reset register block
// Assumes: nothing beyond the header of constants
// Notes:   state_t is the whole register state of the top module
package soft_reset_pkg;

  // one reset line per covered peripheral, active high
  typedef struct packed {
    logic pwm_reset_bit;
    logic adc_reset_bit;
    logic hibernation_reset_bit;
    logic watchdog_reset_bit;
    logic comparator_zero_reset_bit;
    logic timer_two_reset_bit;
    logic timer_one_reset_bit;
    logic timer_zero_reset_bit;
    logic two_wire_zero_reset_bit;
    logic sync_serial_zero_reset_bit;
    logic async_serial_one_reset_bit;
    logic async_serial_zero_reset_bit;
  } periph_rst_t;

  // all flip-flops of the register block
  typedef struct packed {
    logic [31:0] ctl_0;
    logic [31:0] ctl_1;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } state_t;

endpackage

/* rtl/soft_reset_regs.svh */
// Purpose: offsets, field positions and reset values of the soft reset regs
// Assumes: 32-bit apb data, 12-bit byte address, one word per register
// Notes:   writable masks list the bits that hold a peripheral reset line
//
// What this block does
// - capability_mask_1 gates writes to software_reset_ctl_0
// - capability_mask_2 gates writes to software_reset_ctl_1
// - ctl_0 bit 20 resets pulse-width modulator
// - ctl_0 bit 16 resets converter zero
// - ctl_0 bit 6 resets hibernation unit
// - ctl_0 bit 3 resets watchdog
// - ctl_1 bit 24 resets comparator zero
// - ctl_1 bits 18..16 reset timers two..zero
// - ctl_1 bit 12 resets two-wire unit
// - ctl_1 bit 4 resets sync serial
// - ctl_1 bits 1, 0 reset uarts
// - reserved bits read zero, ignore writes
// - both registers reset to all zeros
`ifndef SOFT_RESET_REGS_SVH
`define SOFT_RESET_REGS_SVH

`define SRST_CTL_0_OFFSET   12'h040
`define SRST_CTL_1_OFFSET   12'h044
`define SRST_RESET_VALUE    32'h0000_0000
`define SRST_CTL_0_WMASK    32'h0011_0048
`define SRST_CTL_1_WMASK    32'h0107_1013

`define SRST_PWM_BIT        20
`define SRST_ADC_BIT        16
`define SRST_HIBERNATE_BIT  6
`define SRST_WATCHDOG_BIT   3
`define SRST_COMP_BIT       24
`define SRST_TIMER_TWO_BIT  18
`define SRST_TIMER_ONE_BIT  17
`define SRST_TIMER_ZERO_BIT 16
`define SRST_TWO_WIRE_BIT   12
`define SRST_SYNC_SER_BIT   4
`define SRST_ASYNC1_BIT     1
`define SRST_ASYNC0_BIT     0

`endif
